// ---- verilog/cdm_pkg.sv ----
// Package of constants and types for the clock and modulation mode block
package cdm_pkg;

    // Strap codes from the analogue front end (resistor classes)
    localparam logic [1:0] FREQ_CODE_SHORT   = 2'h0;   // 0 ohm: slave
    localparam logic [1:0] FREQ_CODE_OVER26K = 2'h1;   // > 26 kohm: master
    localparam logic [0:0] LOOP_CODE_GROUND  = 1'h0;   // Tied to analogue ground
    localparam logic [0:0] ADDR_CODE_GROUND  = 1'h0;   // Standalone mode

    localparam logic [2:0] MODE_CODE_0K      = 3'h0;
    localparam logic [2:0] MODE_CODE_4K7     = 3'h1;
    localparam logic [2:0] MODE_CODE_13K     = 3'h2;
    localparam logic [2:0] MODE_CODE_33K     = 3'h3;
    localparam logic [2:0] MODE_CODE_100K    = 3'h4;
    localparam logic [2:0] MODE_CODE_OPEN    = 3'h5;

    // Phase shift field encodings; shift_steps maps them to pi/12 steps
    localparam logic [2:0] SHIFT_NONE        = 3'h0;
    localparam logic [2:0] SHIFT_QUARTER     = 3'h1;
    localparam logic [2:0] SHIFT_THIRD       = 3'h2;
    localparam logic [2:0] SHIFT_HALF        = 3'h3;
    localparam logic [2:0] SHIFT_TWO_THIRDS  = 3'h4;
    localparam logic [2:0] SHIFT_THREE_QUART = 3'h5;

    // Phase accumulator: 24 steps per oscillator period (2 pi)
    localparam int unsigned    PHASE_STEPS   = 24;
    localparam logic [4:0]     PHASE_LAST    = 5'h17;
    localparam logic [4:0]     PHASE_HALF    = 5'h0C;

    // Hop divider counts for nominal, 0.9x and 1.1x master oscillator
    localparam logic [4:0]     OSC_NOMINAL   = 5'h17;
    localparam logic [4:0]     OSC_FAST      = 5'h14;  // 1.1x: fewer steps
    localparam logic [4:0]     OSC_SLOW      = 5'h1A;  // 0.9x: more steps

    // APB register map (byte addresses)
    localparam logic [7:0] REG_CTRL          = 8'h00;
    localparam logic [7:0] REG_STATUS        = 8'h04;

    // Control register field positions
    localparam int unsigned CTRL_HOP_DIR     = 3;
    localparam int unsigned CTRL_HOP_EN      = 4;
    localparam int unsigned CTRL_MOD_INPHASE = 5;
    localparam int unsigned CTRL_SHIFT_LSB   = 1;
    localparam int unsigned CTRL_LATCH       = 7;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;

    // Status register field positions
    localparam int unsigned STAT_MASTER      = 0;
    localparam int unsigned STAT_LOCK        = 1;
    localparam int unsigned STAT_INPHASE     = 2;
    localparam int unsigned STAT_PARALLEL    = 3;
    localparam int unsigned STAT_LATCHED     = 4;
    localparam int unsigned STAT_BUSMODE     = 5;
    localparam int unsigned STAT_SHIFT_LSB   = 8;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_LATCHED = 2'b01,
        ST_RUN     = 2'b10
    } cdm_state_t;

endpackage

// ---- verilog/cdm_sync.sv ----
// Two-flop synchroniser for a vector of pin levels
`timescale 1ns/100ps
module cdm_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta;

    // First stage read only by the second
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta <= '0;
            q_o  <= '0;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule // cdm_sync

// ---- verilog/cdm_mode.sv ----
// Clock role, modulation and phase stagger mode logic with APB registers
//
// Contract
// - Frequency strap over 26 kohm gives master, drives clock pin; short gives slave.
// - Slave with loop strap grounded runs modulators straight from external clock.
// - Phase staggering only in slave role with loop enabled.
// - Standalone: strap sets modulation, half-pi shift, parallel; bus: parallel only.
// - Standalone strap table: 0,100k,13k opposite; 4.7k,33k,open in-phase; 13k,33k half-pi.
// - Bus mode: strap grounded is stereo, 33 kohm is parallel.
// - Bus mode: writing the latch bit as one captures the mode strap.
// - Otherwise the mode strap is captured when outputs first start switching.
// - Opposite-phase modulation drives the bridge halves complementary.
// - In-phase modulation switches both halves together, one input inverted.
// - Switching phase is offset from incoming clock by the selected amount.
// - Bus field picks quarter, third, half, two-thirds or three-quarter pi.
// - Parallel mode runs both stages as one, channel one controls govern.
// - Address strap grounded gives standalone mode, otherwise bus mode.
// - Master with hop enabled runs at 0.9 or 1.1 nominal by direction; here hop applies in bus mode only.
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/100ps
module cdm_mode
    import cdm_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    // Strap codes from the analogue front end
    input  wire logic [1:0]  freq_set_strap_i,
    input  wire logic        spread_loop_strap_i,
    input  wire logic [2:0]  mode_select_strap_i,
    input  wire logic        addr_select_strap_i,
    // Shared clock pin, three signals
    input  wire logic        shared_clock_pin_i,
    output logic             shared_clock_pin_o,
    output logic             shared_clock_pin_oe_b_o,
    // Start of switching from the power stage sequencer
    input  wire logic        switch_start_i,
    // Channel one and channel two modulation inputs
    input  wire logic        ch1_pwm_i,
    input  wire logic        ch2_pwm_i,
    // Bridge half drive
    output logic [1:0]       half_a_o,
    output logic [1:0]       half_b_o,
    output logic             invert_input_o,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation

    logic [7:0] strap_s;
    logic [1:0] clk_pin_s;
    cdm_sync #(.WIDTH(8)) u_strap_sync (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .d_i     ({freq_set_strap_i, spread_loop_strap_i, mode_select_strap_i,
                   addr_select_strap_i, switch_start_i}),
        .q_o     (strap_s)
    );
    cdm_sync #(.WIDTH(2)) u_clk_sync (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .d_i     ({shared_clock_pin_i, 1'b0}),
        .q_o     (clk_pin_s)
    );

    logic [1:0] f_code;
    logic       loop_code;
    logic [2:0] m_code;
    logic       a_code;
    logic       start_s;
    assign f_code    = strap_s[7:6];
    assign loop_code = strap_s[5];
    assign m_code    = strap_s[4:2];
    assign a_code    = strap_s[1];
    assign start_s   = strap_s[0];

    ////////////////////////////////////////////////////////////////////////
    // Decode functions

    function automatic logic mode_inphase(input logic [2:0] c);
        mode_inphase = (c == MODE_CODE_4K7) || (c == MODE_CODE_33K) || (c == MODE_CODE_OPEN);
    endfunction

    function automatic logic mode_half_pi(input logic [2:0] c);
        mode_half_pi = (c == MODE_CODE_13K) || (c == MODE_CODE_33K);
    endfunction

    // Shift code to pi/12 steps; out-of-range codes mean no shift
    function automatic logic [4:0] shift_steps(input logic [2:0] c);
        unique case (c)
            SHIFT_QUARTER:     shift_steps = 5'h03;
            SHIFT_THIRD:       shift_steps = 5'h04;
            SHIFT_HALF:        shift_steps = 5'h06;
            SHIFT_TWO_THIRDS:  shift_steps = 5'h08;
            SHIFT_THREE_QUART: shift_steps = 5'h09;
            default:           shift_steps = 5'h00;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        cdm_state_t  st;
        logic [31:0] ctrl;
        logic [2:0]  mode_latched;
        logic [4:0]  phase;
        logic [4:0]  div;
        logic        osc;
        logic        clk_prev;
        logic        master;
        logic        bus_mode;
        logic [31:0] rdata;
    } cdm_reg_t;

    cdm_reg_t r;
    cdm_reg_t next_r;

    logic       wr_en;
    logic       rd_en;
    logic       lock_en;
    logic       stagger_en;
    logic       bypass;
    logic       inphase;
    logic       parallel;
    logic [4:0] offset;
    logic [4:0] osc_top;
    logic       ext_edge;
    logic [4:0] shifted;
    logic       carrier;
    logic       latch_cmd;

    always_comb begin
        wr_en = psel && penable && pwrite;
        rd_en = psel && !penable && !pwrite;
        // strap capture command, bus mode only
        latch_cmd = r.bus_mode && wr_en && (paddr == REG_CTRL) && pwdata[CTRL_LATCH];
        // loop bypass when slave and loop strap grounded
        lock_en    = !r.master && (loop_code != LOOP_CODE_GROUND);
        bypass     = !r.master && (loop_code == LOOP_CODE_GROUND);
        // stagger only with locked loop in slave role
        stagger_en = lock_en;
        // source of modulation and shift depends on bus mode
        if (r.bus_mode) begin
            inphase = r.ctrl[CTRL_MOD_INPHASE];
            offset  = shift_steps(r.ctrl[CTRL_SHIFT_LSB +: 3]);
            // 33k is parallel, ground is stereo
            parallel = (r.mode_latched == MODE_CODE_33K);
        end else begin
            inphase  = mode_inphase(r.mode_latched);
            offset   = mode_half_pi(r.mode_latched) ? shift_steps(SHIFT_HALF) : 5'h00;
            parallel = mode_half_pi(r.mode_latched) && mode_inphase(r.mode_latched);
        end
        if (!stagger_en) begin
            offset = 5'h00;
        end
        // hop only in bus mode as master
        osc_top = OSC_NOMINAL;
        if (r.bus_mode && r.master && r.ctrl[CTRL_HOP_EN]) begin
            osc_top = r.ctrl[CTRL_HOP_DIR] ? OSC_FAST : OSC_SLOW;
        end
        ext_edge = clk_pin_s[1] && !r.clk_prev;
        shifted = (r.phase >= offset) ? (r.phase - offset)
                                      : 5'(r.phase + 5'(PHASE_STEPS) - offset);
        carrier = (shifted < PHASE_HALF);

        next_r          = r;
        next_r.clk_prev = clk_pin_s[1];
        next_r.master   = (f_code == FREQ_CODE_OVER26K);
        next_r.bus_mode = (a_code != ADDR_CODE_GROUND);
        if (r.master) begin
            if (r.div >= osc_top) begin
                next_r.div = 5'h00;
                next_r.osc = !r.osc;
            end else begin
                next_r.div = 5'(r.div + 5'h01);
            end
        end
        // Phase counter: master self-runs, slave restarts on pin edge
        if (ext_edge && !r.master) begin
            next_r.phase = 5'h00;
        end else if (r.phase >= PHASE_LAST) begin
            next_r.phase = 5'h00;
        end else begin
            next_r.phase = 5'(r.phase + 5'h01);
        end
        if (wr_en && (paddr == REG_CTRL)) begin
            next_r.ctrl = pwdata;
        end
        // command captures the strap whatever the state
        if (latch_cmd) begin
            next_r.mode_latched = m_code;
        end
        unique case (r.st)
            ST_IDLE: begin
                if (latch_cmd) begin
                    next_r.st = ST_LATCHED;
                end else if (start_s) begin
                    next_r.mode_latched = m_code;
                    next_r.st           = ST_RUN;
                end
            end
            ST_LATCHED: begin
                if (start_s) begin
                    next_r.st = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!start_s) begin
                    next_r.st = ST_IDLE;
                end
            end
            default: next_r.st = ST_IDLE;
        endcase
        next_r.ctrl[CTRL_LATCH] = 1'b0;   // Command bit, self-clearing
        if (rd_en) begin
            unique case (paddr)
                REG_CTRL:   next_r.rdata = r.ctrl;
                REG_STATUS: next_r.rdata = {16'h0000, 3'h0, offset, 2'h0, r.bus_mode,
                                            (r.st != ST_IDLE), parallel, inphase, lock_en, r.master};
                default:    next_r.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            r <= '{st: ST_IDLE, ctrl: CTRL_RESET, mode_latched: MODE_CODE_0K, phase: 5'h00,
                   div: 5'h00, osc: 1'b0, clk_prev: 1'b0, master: 1'b0, bus_mode: 1'b0,
                   rdata: 32'h0000_0000};
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    // Bus answers in access phase without wait states
    assign pready  = 1'b1;
    assign pslverr = psel && penable && (paddr != REG_CTRL) && (paddr != REG_STATUS);
    assign prdata  = r.rdata;

    // master drives the pin, enable low means driving
    assign shared_clock_pin_o      = r.osc;
    assign shared_clock_pin_oe_b_o = !r.master;

    // Output stage registers; bypass uses the pin level directly
    logic [1:0] next_a;
    logic [1:0] next_b;
    logic       base_clk;
    logic [1:0] pwm;
    always_comb begin
        // slave without loop follows external clock
        base_clk = bypass ? clk_pin_s[1] : carrier;
        // parallel: channel one drives both stages
        pwm      = parallel ? {ch1_pwm_i, ch1_pwm_i} : {ch2_pwm_i, ch1_pwm_i};
        next_a   = '0;
        next_b   = '0;
        if (r.st == ST_RUN) begin
            next_a = pwm ^ {2{base_clk}};
            // complementary halves / same phase, input inverted
            // In-phase: same switching, inversion goes to the modulator
            next_b = inphase ? next_a : ~next_a;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            half_a_o       <= 2'h0;
            half_b_o       <= 2'h0;
            invert_input_o <= 1'b0;
        end else begin
            half_a_o       <= next_a;
            half_b_o       <= next_b;
            invert_input_o <= inphase;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    a_role_master: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (f_code == FREQ_CODE_OVER26K) |=> shared_clock_pin_oe_b_o == 1'b0)
        else $error("master role not driving clock pin");
    a_no_stagger: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !lock_en |-> offset == 5'h00)
        else $error("phase offset applied without loop");
    a_latch_cmd: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        latch_cmd |=> r.mode_latched == $past(m_code))
        else $error("strap not latched on command");
    a_inphase_same: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (r.st == ST_RUN && inphase) |=> half_b_o == half_a_o)
        else $error("halves not switching in phase");
    a_latch_start: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (r.st == ST_IDLE && start_s && !wr_en) |=> r.st == ST_RUN && r.mode_latched == $past(m_code))
        else $error("strap not latched at switching start");
    a_opposite_phase: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (r.st == ST_RUN && !inphase) |=> half_b_o == ~half_a_o)
        else $error("halves not complementary");
    a_bus_parallel: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (r.bus_mode && r.mode_latched == MODE_CODE_0K) |-> !parallel)
        else $error("ground strap not stereo in bus mode");
    a_mode_source: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (a_code == ADDR_CODE_GROUND) [*2] |-> !r.bus_mode)
        else $error("standalone mode not entered");
    a_hop_period: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (r.master && r.bus_mode && r.ctrl[CTRL_HOP_EN] && r.ctrl[CTRL_HOP_DIR]) |-> osc_top == OSC_FAST)
        else $error("hop direction not applied");

    c_latched_cmd: cover property (@(posedge clk_i) r.st == ST_LATCHED ##1 r.st == ST_RUN);
    c_stagger:     cover property (@(posedge clk_i) stagger_en && offset != 5'h00);
    c_inphase_run: cover property (@(posedge clk_i) r.st == ST_RUN && inphase);

endmodule // cdm_mode

// ---- sim/cdm_osc_model.sv ----
// External oscillator model standing on the shared clock pin
`timescale 1ns/100ps
module cdm_osc_model #(
    parameter int unsigned HALF_NS = 1200
) (
    input  wire logic run_i,
    input  wire logic slow_i,
    output logic      osc_o
);
    ////////////////////////////////////////////////////////////////////////////
    // external slave clock
    // Free-running square wave; slow doubles the half period
    initial begin
        osc_o = 1'b0;
        forever begin
            if (run_i) begin
                #(slow_i ? HALF_NS * 2 : HALF_NS);
                osc_o = ~osc_o;
            end else begin
                #(HALF_NS);
                osc_o = 1'b0;   // Parked, not toggling
            end
        end
    end
endmodule // cdm_osc_model

// ---- sim/test_class_d_clock_and_modulation_mode.sv ----
// Self-checking bench for the clock and modulation mode block
`timescale 1ns/100ps
module test_class_d_clock_and_modulation_mode;
    import cdm_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic [1:0]  freq = 2'h0;
    logic        loop = 1'b1;
    logic [2:0]  mode = 3'h0;
    logic        addr = 1'b0;
    logic        sw = 1'b0;
    logic        ch1 = 1'b1;
    logic        ch2 = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pin_o;
    logic        oe_b;
    logic        osc;
    logic        pin;
    logic [1:0]  half_a;
    logic [1:0]  half_b;
    logic        inv;
    logic [31:0] rd;
    logic        er;
    int          err_count = 0;
    int          cmp_count = 0;
    int          per;
    logic [4:0]  offs [7] = '{5'd0, 5'd3, 5'd4, 5'd6, 5'd8, 5'd9, 5'd0};

    // Wire level: device drives while its enable is low
    assign pin = oe_b ? osc : pin_o;
    always #50 clk_i = ~clk_i;

    cdm_osc_model cdm_osc_model_i (.run_i(1'b1), .slow_i(1'b0), .osc_o(osc));
    cdm_mode cdm_mode_i (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .freq_set_strap_i(freq), .spread_loop_strap_i(loop),
        .mode_select_strap_i(mode), .addr_select_strap_i(addr), .shared_clock_pin_i(pin),
        .shared_clock_pin_o(pin_o), .shared_clock_pin_oe_b_o(oe_b), .switch_start_i(sw),
        .ch1_pwm_i(ch1), .ch2_pwm_i(ch2), .half_a_o(half_a), .half_b_o(half_b), .invert_input_o(inv),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    ////////////////////////////////////////////////////////////////////////////
    // Comparison and closing
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // One APB transfer; held until pready seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do begin @(posedge clk_i); n++; end while (pready !== 1'b1 && n < 50);
        // A bus that never answers ends the run as a failure
        if (pready !== 1'b1) begin
            err_count++;
            report_and_stop();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    function automatic logic [31:0] st(input logic m, l, i, p, lt, b, input logic [4:0] off);
        st = 32'h0000_0000;
        st[STAT_MASTER] = m; st[STAT_LOCK] = l; st[STAT_INPHASE] = i; st[STAT_PARALLEL] = p;
        st[STAT_LATCHED] = lt; st[STAT_BUSMODE] = b; st[STAT_SHIFT_LSB +: 5] = off;
    endfunction
    // Straps change in idle, then switching starts the capture
    task automatic start(input logic [1:0] f, input logic l, input logic [2:0] m, input logic a);
        @(posedge clk_i);
        sw <= 1'b0; freq <= f; loop <= l; mode <= m; addr <= a;
        idle(8);
        sw <= 1'b1;
        idle(8);
    endtask
    // Cycles between two rising edges of the driven clock pin
    task automatic period;
        logic pv;
        int n;
        per = 0; n = 0; pv = 1'b1;
        while (!(pv == 1'b0 && pin_o == 1'b1) && n < 200) begin pv = pin_o; @(posedge clk_i); n++; end
        pv = 1'b1;
        do begin pv = pin_o; @(posedge clk_i); per++; end while (!(pv == 1'b0 && pin_o == 1'b1) && per < 200);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog: tests need under a thousand cycles, limit is 20000
    initial begin
        #2_000_000;
        err_count++;
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        idle(6);
        chk("oe_b in reset", oe_b, 1); // pin released
        rst_b_i <= 1'b1;
        // Standalone strap table, slave with loop
        for (int k = 0; k < 6; k++) begin
            start(2'h0, 1'b1, k[2:0], 1'b0);
            apb(1'b0, REG_STATUS, 0);
            chk("status", rd, st(0, 1, k[0], k == 3, 1, 0, (k == 2 || k == 3) ? 5'd6 : 5'd0)); // table
            chk("invert", inv, k[0]); // inverted input
            chk("halves", half_a ^ half_b, k[0] ? 2'b00 : 2'b11); // complementary
            chk("stages", half_a[1] ^ half_a[0], k != 3); // joined stages
        end
        @(posedge clk_i);
        mode <= MODE_CODE_33K;
        idle(8);
        apb(1'b0, REG_STATUS, 0);
        chk("held strap", rd, st(0, 1, 1, 0, 1, 0, 0)); // capture once
        start(2'h0, 1'b0, MODE_CODE_13K, 1'b0);
        apb(1'b0, REG_STATUS, 0);
        chk("no loop", rd, st(0, 0, 0, 0, 1, 0, 0)); // no shift
        start(FREQ_CODE_OVER26K, 1'b0, MODE_CODE_13K, 1'b0);
        chk("master pin", oe_b, 0); // drives pin
        apb(1'b0, REG_STATUS, 0);
        chk("master", rd, st(1, 0, 0, 0, 1, 0, 0)); // master unshifted
        $display("standalone tests done");
        // Bus mode: strap latched by command
        @(posedge clk_i);
        sw <= 1'b0; freq <= 2'h0; loop <= 1'b1; mode <= MODE_CODE_33K; addr <= 1'b1;
        idle(8);
        chk("slave pin", oe_b, 1); // pin input
        apb(1'b1, REG_CTRL, 32'h0000_0080);
        apb(1'b0, REG_CTRL, 0);
        chk("latch clears", rd, 32'h0000_0000); // self clearing
        apb(1'b0, REG_STATUS, 0);
        chk("bus parallel", rd, st(0, 1, 0, 1, 1, 1, 0)); // parallel
        @(posedge clk_i);
        mode <= MODE_CODE_0K;
        idle(8);
        apb(1'b0, REG_STATUS, 0);
        chk("bus hold", rd, st(0, 1, 0, 1, 1, 1, 0)); // held value
        apb(1'b1, REG_CTRL, 32'h0000_0080);
        apb(1'b0, REG_STATUS, 0);
        chk("bus stereo", rd, st(0, 1, 0, 0, 1, 1, 0)); // stereo
        @(posedge clk_i);
        sw <= 1'b1;
        for (int s = 0; s < 7; s++) begin
            apb(1'b1, REG_CTRL, 32'h0000_0020 | (s << CTRL_SHIFT_LSB));
            idle(4);
            apb(1'b0, REG_STATUS, 0);
            chk("bus shift", rd, st(0, 1, 1, 0, 1, 1, offs[s])); // shift table
            chk("bus invert", inv, 1); // bus modulation
        end
        $display("bus tests done");
        // Hop on a bus-mode master
        @(posedge clk_i);
        freq <= FREQ_CODE_OVER26K; loop <= 1'b0;
        for (int h = 0; h < 3; h++) begin
            apb(1'b1, REG_CTRL, h == 0 ? 32'h0000_0000 : (h == 2 ? 32'h0000_0018 : 32'h0000_0010));
            idle(60);
            period();
            // Pin toggles after each full count, so one period is two counts
            chk("osc period", per, 2 * (h == 0 ? OSC_NOMINAL + 1 // hop
                : (h == 1 ? OSC_SLOW + 1 : OSC_FAST + 1)));
        end
        $display("hop tests done");
        // Unmapped address refused
        apb(1'b1, 8'h0C, 32'h0000_0010);
        apb(1'b0, 8'h08, 0);
        chk("unmapped data", rd, 32'h0000_0000); // bus commands
        chk("unmapped err", er, 1); // bus commands
        apb(1'b0, REG_CTRL, 0);
        chk("ctrl kept", rd, 32'h0000_0018); // hop bits kept
        $display("refusal tests done");
        report_and_stop();
    end
endmodule // test_class_d_clock_and_modulation_mode
